/* logic/snoop_issue_pkg.sv */
// shared types and constants for the snoop issue controller
package snoop_issue_pkg;

  localparam int N_MASTERS = 4;
  localparam int MID_W = 2;
  localparam int ADDR_W = 32;
  localparam int LINE_SHIFT = 6;

  // transaction codes from the initiating masters
  typedef enum logic [4:0] {
    txn_read_no_snoop = 5'h00,
    txn_read_once = 5'h01,
    txn_read_clean = 5'h02,
    txn_read_not_shared_dirty = 5'h03,
    txn_read_shared = 5'h04,
    txn_read_unique = 5'h05,
    txn_clean_unique = 5'h06,
    txn_make_unique = 5'h07,
    txn_clean_shared = 5'h08,
    txn_clean_invalid = 5'h09,
    txn_make_invalid = 5'h0a,
    txn_write_no_snoop = 5'h0b,
    txn_write_unique = 5'h0c,
    txn_write_line_unique = 5'h0d,
    txn_write_back = 5'h0e,
    txn_write_clean = 5'h0f,
    txn_write_evict = 5'h10,
    txn_evict = 5'h11
  } txn_t;

  // snoop codes driven to the cached masters
  typedef enum logic [3:0] {
    snp_read_once = 4'h0,
    snp_read_shared = 4'h1,
    snp_read_clean = 4'h2,
    snp_read_not_shared_dirty = 4'h3,
    snp_read_unique = 4'h7,
    snp_clean_shared = 4'h8,
    snp_clean_invalid = 4'h9,
    snp_make_invalid = 4'hd
  } snoop_t;

  // why snooping stopped
  typedef enum logic [2:0] {
    stop_no_snoop = 3'b000,
    stop_copy = 3'b001,
    stop_dirty = 3'b010,
    stop_was_unique = 3'b011,
    stop_all_snooped = 3'b100
  } stop_t;

  // snoop response bit positions
  localparam int CR_DATA_XFER = 0;
  localparam int CR_PASS_DIRTY = 2;
  localparam int CR_IS_SHARED = 3;
  localparam int CR_WAS_UNIQUE = 4;

  // register byte offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam int CTRL_MI_AFTER_DIRTY = 0;
  localparam int CTRL_USE_READ_UNIQUE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CONT = 1;
  localparam int STAT_CAUSE_LSB = 4;

  typedef struct packed {
    txn_t txn;
    logic [MID_W-1:0] init_id;
    logic [ADDR_W-1:0] addr;
    logic line_sized;
    logic nonshare_cacheable;
    logic [N_MASTERS-1:0] holders;
  } txn_req_t;

  typedef struct packed {
    snoop_t snp;
    logic [N_MASTERS-1:0] target;
    logic [ADDR_W-1:0] addr;
  } snoop_req_t;

endpackage : snoop_issue_pkg

/* logic/line_ack_tracker.sv */
// per master guard: awaited acknowledge and continuous line return window
`timescale 1ns/1ns
`default_nettype none
module line_ack_tracker
  import snoop_issue_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic resp_sent,
  input wire logic [ADDR_W-1:0] resp_addr,
  input wire logic ack,
  input wire logic [ADDR_W-1:0] check_addr,
  input wire logic mark_qual,
  input wire logic rbeat_valid,
  input wire logic rbeat_last,
  output logic blocked,
  output logic in_line
);

  typedef struct packed {
    logic pending;
    logic [ADDR_W-LINE_SHIFT-1:0] line;
    logic qual;
    logic in_line;
  } trk_t;

  trk_t st;
  trk_t next_st;

  // ack is taken the cycle it shows; no way exists to hold it off
  always_comb
  begin
    next_st = st;
    if (ack)
      next_st.pending = 1'b0;
    if (resp_sent)
    begin
      next_st.pending = 1'b1;
      next_st.line = resp_addr[ADDR_W-1:LINE_SHIFT];
    end
    if (mark_qual)
      next_st.qual = 1'b1;
    if (rbeat_valid && st.qual && !st.in_line && !rbeat_last)
      next_st.in_line = 1'b1;
    if (rbeat_valid && rbeat_last)
    begin
      next_st.in_line = 1'b0;
      next_st.qual = mark_qual;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  // same line snoop held while the acknowledge is owed
  assign blocked = st.pending && (st.line == check_addr[ADDR_W-1:LINE_SHIFT]);
  assign in_line = st.in_line;

endmodule : line_ack_tracker
`default_nettype wire

/* logic/coherent_snoop_issue_control.sv */
// snoop issue controller: target choice, snoop type and stop condition
`timescale 1ns/1ns
`default_nettype none
module coherent_snoop_issue_control
  import snoop_issue_pkg::*;
#(
  parameter bit CONT_LINE_READ = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire txn_req_t req,
  output logic req_ready,
  output logic snp_valid,
  input wire logic snp_ready,
  output snoop_req_t snp,
  input wire logic cr_valid,
  input wire logic [4:0] cr_resp,
  input wire logic resp_sent_valid,
  input wire logic [MID_W-1:0] resp_sent_id,
  input wire logic [ADDR_W-1:0] resp_sent_addr,
  input wire logic [N_MASTERS-1:0] rack,
  input wire logic [N_MASTERS-1:0] wack,
  input wire logic [N_MASTERS-1:0] rbeat_valid,
  input wire logic [N_MASTERS-1:0] rbeat_last,
  output logic [N_MASTERS-1:0] r_stall,
  output logic done_valid,
  output stop_t done_cause,
  output logic done_pass_dirty,
  output logic [2:0] done_snoops,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_pick = 3'b001,
    st_issue = 3'b010,
    st_wait = 3'b011,
    st_done = 3'b100
  } fsm_t;

  typedef enum logic [1:0] {
    cls_none = 2'b00,
    cls_read = 2'b01,
    cls_clean_shared = 2'b10,
    cls_invalidate = 2'b11
  } cls_t;

  typedef struct packed {
    fsm_t fsm;
    txn_req_t cur;
    cls_t cls;
    logic [N_MASTERS-1:0] remaining;
    logic dirty_seen;
    stop_t cause;
    logic [2:0] snoops;
    logic req_ready;
    logic snp_valid;
    snoop_req_t snp;
    logic [N_MASTERS-1:0] r_stall;
    logic done_valid;
    logic [1:0] ctrl;
    logic [15:0] txn_count;
    logic [15:0] snoop_count;
    logic [31:0] readdata;
    logic waitrequest;
    logic cont;
  } state_t;

  state_t st;
  state_t next_st;

  logic [N_MASTERS-1:0] blocked;
  logic [N_MASTERS-1:0] in_line;
  logic [N_MASTERS-1:0] sent_one;
  logic [N_MASTERS-1:0] qual_one;
  logic accept;
  logic qualifying;

  // class of a transaction decides whether and how long to snoop
  function automatic cls_t classify(input txn_t t);
    case (t)
      txn_read_once, txn_read_clean, txn_read_not_shared_dirty, txn_read_shared:
        classify = cls_read;
      txn_clean_shared:
        classify = cls_clean_shared;
      txn_read_unique, txn_clean_unique, txn_make_unique, txn_clean_invalid,
      txn_make_invalid, txn_write_unique, txn_write_line_unique:
        classify = cls_invalidate;
      default:
        classify = cls_none;
    endcase
  endfunction : classify

  // snoop choice per target; every choice leaves the required end state
  function automatic snoop_t pick_snoop(input txn_t t, input logic [1:0] ctrl, input logic dirty);
    snoop_t s;
    s = snp_clean_invalid;
    case (t)
      txn_read_once: s = snp_read_once;
      txn_read_clean: s = snp_read_clean;
      txn_read_not_shared_dirty: s = snp_read_not_shared_dirty;
      txn_read_shared: s = snp_read_shared;
      txn_clean_shared: s = snp_clean_shared;
      txn_read_unique: s = snp_read_unique;
      txn_clean_unique, txn_write_unique, txn_clean_invalid: s = snp_clean_invalid;
      txn_make_unique, txn_write_line_unique, txn_make_invalid: s = snp_make_invalid;
      default: s = snp_clean_invalid;
    endcase
    // read unique is a legal stand-in for every invalidating kind
    if (ctrl[CTRL_USE_READ_UNIQUE] && classify(t) == cls_invalidate)
      s = snp_read_unique;
    // once dirty data has moved, later targets need no data back
    if (ctrl[CTRL_MI_AFTER_DIRTY] && dirty &&
        (t == txn_write_unique || t == txn_read_unique || t == txn_clean_unique || t == txn_clean_invalid))
      s = snp_make_invalid;
    pick_snoop = s;
  endfunction : pick_snoop

  // qualifying line sized reads for continuous return
  always_comb
  begin
    case (req.txn)
      txn_read_clean, txn_read_shared, txn_read_unique, txn_read_not_shared_dirty:
        qualifying = 1'b1;
      txn_read_once:
        qualifying = req.line_sized;
      txn_read_no_snoop:
        qualifying = req.line_sized && req.nonshare_cacheable;
      default:
        qualifying = 1'b0;
    endcase
  end

  assign accept = req_valid && st.req_ready;

  // per master decode of response and request events
  always_comb
  begin
    sent_one = '0;
    qual_one = '0;
    sent_one[resp_sent_id] = resp_sent_valid;
    qual_one[req.init_id] = accept && qualifying;
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_MASTERS; gi++)
    begin : g_trk
      line_ack_tracker u_trk (
        .core_clk(core_clk),
        .rst(rst),
        .resp_sent(sent_one[gi]),
        .resp_addr(resp_sent_addr),
        .ack(rack[gi] || wack[gi]),
        .check_addr(st.cur.addr),
        .mark_qual(qual_one[gi]),
        .rbeat_valid(rbeat_valid[gi]),
        .rbeat_last(rbeat_last[gi]),
        .blocked(blocked[gi]),
        .in_line(in_line[gi])
      );
    end
  endgenerate

  // whole next state: sequencer, bus slave and counters
  always_comb
  begin
    logic [N_MASTERS-1:0] tgt;
    logic stop;
    next_st = st;
    tgt = '0;
    stop = 1'b0;
    next_st.done_valid = 1'b0;
    next_st.cont = CONT_LINE_READ;

    case (st.fsm)
      st_idle:
      begin
        next_st.req_ready = 1'b1;
        if (accept)
        begin
          next_st.req_ready = 1'b0;
          next_st.cur = req;
          next_st.cls = classify(req.txn);
          next_st.dirty_seen = 1'b0;
          next_st.snoops = 3'h0;
          next_st.txn_count = st.txn_count + 16'h1;
          // initiator is never a candidate
          next_st.remaining = req.holders & ~(N_MASTERS'(1) << req.init_id);
          if (classify(req.txn) == cls_none)
          begin
            next_st.cause = stop_no_snoop;
            next_st.fsm = st_done;
          end
          else
            next_st.fsm = st_pick;
        end
      end
      st_pick:
      begin
        // lowest unsnooped candidate, one target at a time
        for (int i = N_MASTERS - 1; i >= 0; i--)
          if (st.remaining[i])
            tgt = N_MASTERS'(1) << i;
        if (st.remaining == '0)
        begin
          next_st.cause = stop_all_snooped;
          next_st.fsm = st_done;
        end
        // hold off while an ack is owed or the target is mid line return
        else if (((tgt & blocked) == '0) && ((tgt & in_line) == '0 || !CONT_LINE_READ))
        begin
          next_st.snp.target = tgt;
          next_st.snp.addr = st.cur.addr;
          next_st.snp.snp = pick_snoop(st.cur.txn, st.ctrl, st.dirty_seen);
          next_st.snp_valid = 1'b1;
          next_st.remaining = st.remaining & ~tgt;
          next_st.fsm = st_issue;
        end
      end
      st_issue:
      begin
        if (snp_ready)
        begin
          next_st.snp_valid = 1'b0;
          next_st.snoops = st.snoops + 3'h1;
          next_st.snoop_count = st.snoop_count + 16'h1;
          next_st.fsm = st_wait;
        end
      end
      st_wait:
      begin
        if (cr_valid)
        begin
          if (cr_resp[CR_PASS_DIRTY])
            next_st.dirty_seen = 1'b1;
          if (cr_resp[CR_WAS_UNIQUE])
          begin
            stop = 1'b1;
            next_st.cause = stop_was_unique;
          end
          else if (st.cls == cls_read && cr_resp[CR_DATA_XFER])
          begin
            stop = 1'b1;
            next_st.cause = stop_copy;
          end
          else if (st.cls == cls_clean_shared && cr_resp[CR_PASS_DIRTY])
          begin
            stop = 1'b1;
            next_st.cause = stop_dirty;
          end
          // no further snoops for the line once a stop is met
          if (stop)
          begin
            next_st.remaining = '0;
            next_st.fsm = st_done;
          end
          else
            next_st.fsm = st_pick;
        end
      end
      st_done:
      begin
        next_st.done_valid = 1'b1;
        next_st.fsm = st_idle;
      end
      default:
        next_st.fsm = st_idle;
    endcase

    // line return waits on a snoop only when continuous return is off
    for (int m = 0; m < N_MASTERS; m++)
      next_st.r_stall[m] = !CONT_LINE_READ && st.snp.target[m] &&
                           (st.fsm == st_issue || st.fsm == st_wait) && !in_line[m];

    // avalon slave: one wait cycle, answer on the following edge
    next_st.waitrequest = 1'b1;
    if ((avs_read || avs_write) && st.waitrequest)
    begin
      next_st.waitrequest = 1'b0;
      case (avs_address)
        REG_CTRL: next_st.readdata = {30'h0, st.ctrl};
        REG_STATUS: next_st.readdata = {25'h0, st.cause, 2'h0, st.cont, (st.fsm != st_idle)};
        REG_COUNT: next_st.readdata = {st.snoop_count, st.txn_count};
        default: next_st.readdata = 32'h0;
      endcase
    end
    if (avs_write && !st.waitrequest && avs_address == REG_CTRL)
      next_st.ctrl = avs_writedata[1:0];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.fsm <= st_idle;
      st.cls <= cls_none;
      st.cause <= stop_no_snoop;
      st.ctrl <= CTRL_RESET;
      st.waitrequest <= 1'b1;
    end
    else
      st <= next_st;
  end

  // outputs come straight from the state register
  assign req_ready = st.req_ready;
  assign snp_valid = st.snp_valid;
  assign snp = st.snp;
  assign r_stall = st.r_stall;
  assign done_valid = st.done_valid;
  assign done_cause = st.cause;
  assign done_pass_dirty = st.dirty_seen;
  assign done_snoops = st.snoops;
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;

endmodule : coherent_snoop_issue_control
`default_nettype wire

/* tb/snooped_cache_model.sv */
// snooped cache model: takes snoops and answers from a per master table
`timescale 1ns/1ns
`default_nettype none
module snooped_cache_model
  import snoop_issue_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic snp_valid,
  input wire snoop_req_t snp,
  input wire logic [N_MASTERS-1:0][4:0] resp_tab,
  input wire logic [1:0] delay,
  output logic snp_ready,
  output logic cr_valid,
  output logic [4:0] cr_resp
);
  logic [1:0] waited;
  logic [4:0] pick;
  // answer of the one-hot target
  always_comb
  begin
    pick = 5'h00;
    for (int i = 0; i < N_MASTERS; i++)
      if (snp.target[i])
        pick = resp_tab[i];
  end
  // ready delay+1 cycles after valid is first seen, whole response one cycle after taking
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      snp_ready <= 1'b0;
      cr_valid <= 1'b0;
      cr_resp <= 5'h00;
      waited <= 2'h0;
    end
    else
    begin
      snp_ready <= 1'b0;
      cr_valid <= 1'b0;
      cr_resp <= ~cr_resp; // outside the pulse the last answer is inverted every cycle
      if (snp_valid && snp_ready)
      begin
        cr_valid <= 1'b1;
        cr_resp <= pick;
        waited <= 2'h0;
      end
      else if (snp_valid && waited >= delay)
        snp_ready <= 1'b1;
      else if (snp_valid)
        waited <= waited + 2'h1;
    end
  end
endmodule : snooped_cache_model
`default_nettype wire

/* tb/snoop_issue_sva.sv */
// port assertions for the snoop issue controller
`timescale 1ns/1ns
`default_nettype none
module snoop_issue_sva
  import snoop_issue_pkg::*;
#(
  parameter bit CONT_LINE_READ = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire txn_req_t req,
  input wire logic req_ready,
  input wire logic snp_valid,
  input wire snoop_req_t snp,
  input wire logic cr_valid,
  input wire logic [4:0] cr_resp,
  input wire logic [N_MASTERS-1:0] r_stall,
  input wire logic done_valid,
  input wire stop_t done_cause
);
  txn_req_t cur;
  logic quiet;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic bit no_snoop(txn_t t);
    return t inside {txn_read_no_snoop, txn_write_no_snoop, txn_write_back, txn_write_clean, txn_write_evict, txn_evict};
  endfunction : no_snoop
  // end state kept by the snoop kind; make invalid allowed as snooping is sequential
  function automatic bit kind_ok(txn_t t, snoop_t s);
    case (t)
      txn_read_once: return s != snp_make_invalid;
      txn_read_clean, txn_read_not_shared_dirty, txn_read_shared:
        return s inside {snp_read_clean, snp_read_not_shared_dirty, snp_read_shared, snp_read_unique, snp_clean_invalid};
      txn_clean_shared: return s inside {snp_read_unique, snp_clean_invalid, snp_clean_shared};
      default: return s inside {snp_read_unique, snp_clean_invalid, snp_make_invalid};
    endcase
  endfunction : kind_ok
  // transaction captured when taken; quiet while a no-snoop kind runs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      quiet <= 1'b0;
    end
    else if (req_valid && req_ready)
    begin
      cur <= req;
      quiet <= no_snoop(req.txn);
    end
    else if (done_valid)
      quiet <= 1'b0;
  end
  AST_NO_INIT: assert property (snp_valid |-> !snp.target[cur.init_id])
    else $error("snoop sent to initiator");
  AST_HOLDER: assert property (snp_valid |-> $onehot(snp.target) && (snp.target & ~cur.holders) == '0)
    else $error("snoop outside holder set");
  AST_QUIET: assert property (quiet |-> !snp_valid)
    else $error("snoop for no-snoop kind");
  AST_QUIET_DONE: assert property (req_valid && req_ready && no_snoop(req.txn) |-> ##[1:3] (done_valid && done_cause == stop_no_snoop))
    else $error("no-snoop kind not finished");
  AST_KIND: assert property (snp_valid |-> kind_ok(cur.txn, snp.snp))
    else $error("snoop kind not permitted");
  AST_UNIQUE: assert property (cr_valid && cr_resp[CR_WAS_UNIQUE] |=> !snp_valid throughout ##[0:2] (done_valid && done_cause == stop_was_unique))
    else $error("no stop on unique answer");
  AST_DIRTY: assert property (cr_valid && cr_resp[CR_PASS_DIRTY] && !cr_resp[CR_WAS_UNIQUE] && cur.txn == txn_clean_shared |=> !snp_valid throughout ##[0:2] (done_valid && done_cause == stop_dirty))
    else $error("no stop on dirty answer");
  AST_COPY: assert property (cr_valid && cr_resp[CR_DATA_XFER] && !cr_resp[CR_WAS_UNIQUE] && cur.txn inside {txn_read_once, txn_read_clean, txn_read_not_shared_dirty, txn_read_shared} |=> !snp_valid throughout ##[0:2] (done_valid && done_cause == stop_copy))
    else $error("no stop on copy");
  AST_CONT: assert property (CONT_LINE_READ |-> r_stall == '0)
    else $error("line read held back");
  AST_ONE: assert property (snp_valid |-> !req_ready)
    else $error("request taken mid snoop");
  COV_COPY: cover property (done_valid && done_cause == stop_copy);
  COV_DIRTY: cover property (done_valid && done_cause == stop_dirty);
  COV_ALL: cover property (done_valid && done_cause == stop_all_snooped);
endmodule : snoop_issue_sva
bind coherent_snoop_issue_control snoop_issue_sva #(.CONT_LINE_READ(CONT_LINE_READ)) sva (.core_clk(core_clk),
  .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready), .snp_valid(snp_valid), .snp(snp),
  .cr_valid(cr_valid), .cr_resp(cr_resp), .r_stall(r_stall), .done_valid(done_valid), .done_cause(done_cause));
`default_nettype wire

/* tb/tb_coherent_snoop_issue_control.sv */
// self-checking bench for the snoop issue controller
`timescale 1ns/1ns
`default_nettype none
module tb_coherent_snoop_issue_control
  import snoop_issue_pkg::*;
;
  localparam bit CONT = 1'b1;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  txn_req_t req = '0;
  logic req_ready, snp_valid, snp_ready, cr_valid, done_valid, done_pass_dirty, avs_waitrequest;
  snoop_req_t snp;
  logic [4:0] cr_resp;
  logic resp_sent_valid = 1'b0;
  logic [MID_W-1:0] resp_sent_id = '0;
  logic [ADDR_W-1:0] resp_sent_addr = '0;
  logic [N_MASTERS-1:0] rack = '0;
  logic [N_MASTERS-1:0] rbeat_valid = '0;
  logic [N_MASTERS-1:0] rbeat_last = '0;
  logic [N_MASTERS-1:0] r_stall;
  stop_t done_cause;
  logic [2:0] done_snoops;
  logic [3:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd;
  logic [N_MASTERS-1:0][4:0] resp_tab = '0;
  logic [1:0] delay = 2'h0;
  snoop_req_t log_q [8];
  int ns;
  int fails = 0;
  int n_tests = 0;
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  // wack tied off; read beats move only in the continuous return scenario
  coherent_snoop_issue_control #(.CONT_LINE_READ(CONT)) uut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .snp_valid(snp_valid), .snp_ready(snp_ready), .snp(snp), .cr_valid(cr_valid),
    .cr_resp(cr_resp), .resp_sent_valid(resp_sent_valid), .resp_sent_id(resp_sent_id), .resp_sent_addr(resp_sent_addr),
    .rack(rack), .wack(4'h0), .rbeat_valid(rbeat_valid), .rbeat_last(rbeat_last), .r_stall(r_stall),
    .done_valid(done_valid),
    .done_cause(done_cause), .done_pass_dirty(done_pass_dirty), .done_snoops(done_snoops), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  snooped_cache_model far (.core_clk(core_clk), .rst(rst), .snp_valid(snp_valid), .snp(snp), .resp_tab(resp_tab),
    .delay(delay), .snp_ready(snp_ready), .cr_valid(cr_valid), .cr_resp(cr_resp));
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one register access, held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    // only the watchdog ends a wait that never gets an answer
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : avs
  // one transaction, logging every snoop taken until done
  task automatic run(input txn_t t, input logic [1:0] id, input logic [3:0] h);
    req <= '{t, id, 32'h0000_1040, 1'b1, 1'b0, h};
    req_valid <= 1'b1;
    @(posedge core_clk);
    while (req_ready !== 1'b1)
      @(posedge core_clk);
    req_valid <= 1'b0;
    ns = 0;
    while (done_valid !== 1'b1)
    begin
      @(posedge core_clk);
      if (snp_valid === 1'b1 && snp_ready === 1'b1 && ns < 8)
      begin
        log_q[ns] = snp;
        ns++;
      end
    end
  endtask : run
  task automatic t_regs();
    avs(1'b0, REG_STATUS, 32'h0);
    chk(rd[STAT_CONT], CONT);
    avs(1'b1, REG_CTRL, 32'h0000_0003);
    avs(1'b1, 4'hc, 32'hffff_ffff);
    avs(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0000_0003);
    avs(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    avs(1'b1, REG_CTRL, {30'h0, CTRL_RESET});
  endtask : t_regs
  task automatic t_quiet();
    txn_t q[6] = '{txn_read_no_snoop, txn_write_no_snoop, txn_write_back, txn_write_clean, txn_write_evict, txn_evict};
    foreach (q[i])
    begin
      run(q[i], 2'h0, 4'hf);
      chk(ns, 0);
      chk(done_cause, stop_no_snoop);
    end
  endtask : t_quiet
  task automatic t_map();
    txn_t mt[12] = '{txn_read_once, txn_read_clean, txn_read_not_shared_dirty, txn_read_shared, txn_read_unique,
      txn_clean_unique, txn_make_unique, txn_clean_shared, txn_clean_invalid, txn_make_invalid, txn_write_unique,
      txn_write_line_unique};
    snoop_t ms[12] = '{snp_read_once, snp_read_clean, snp_read_not_shared_dirty, snp_read_shared, snp_read_unique,
      snp_clean_invalid, snp_make_invalid, snp_clean_shared, snp_clean_invalid, snp_make_invalid, snp_clean_invalid,
      snp_make_invalid};
    resp_tab <= '0;
    foreach (mt[i])
    begin
      run(mt[i], 2'h0, 4'h2);
      chk(ns, 1);
      chk(log_q[0].snp, ms[i]);
      chk(done_cause, stop_all_snooped);
    end
  endtask : t_map
  task automatic t_stops();
    delay <= 2'h2;
    resp_tab <= {5'h01, 5'h00, 5'h00, 5'h00};
    run(txn_read_shared, 2'h1, 4'hf);
    chk(log_q[0].target, 4'h1);
    chk(log_q[1].target, 4'h4);
    chk(log_q[2].target, 4'h8);
    chk(done_cause, stop_copy);
    chk(done_snoops, 3'h3);
    delay <= 2'h0;
    resp_tab <= {5'h00, 5'h00, 5'h05, 5'h01};
    run(txn_clean_shared, 2'h3, 4'h7);
    chk(ns, 2);
    chk(done_cause, stop_dirty);
    chk(done_pass_dirty, 1'b1);
    resp_tab <= {5'h00, 5'h10, 5'h05, 5'h00};
    run(txn_make_invalid, 2'h0, 4'he);
    chk(ns, 2);
    chk(done_cause, stop_was_unique);
  endtask : t_stops
  task automatic t_ctrl();
    avs(1'b1, REG_CTRL, 32'h0000_0001);
    resp_tab <= {5'h00, 5'h00, 5'h05, 5'h00};
    run(txn_write_unique, 2'h0, 4'he);
    chk(ns, 3);
    chk(log_q[0].snp, snp_clean_invalid);
    chk(log_q[1].snp, snp_make_invalid);
    avs(1'b1, REG_CTRL, 32'h0000_0002);
    run(txn_clean_invalid, 2'h0, 4'h2);
    chk(log_q[0].snp, snp_read_unique);
    avs(1'b1, REG_CTRL, 32'h0);
  endtask : t_ctrl
  // response to master 1 on this line holds its snoop until rack
  task automatic t_ack();
    logic seen = 1'b0;
    resp_sent_id <= 2'h1;
    resp_sent_addr <= 32'h0000_1078;
    resp_sent_valid <= 1'b1;
    @(posedge core_clk);
    resp_sent_valid <= 1'b0;
    resp_tab <= '0;
    fork
      run(txn_read_shared, 2'h0, 4'h2);
      begin
        repeat (8)
        begin
          @(posedge core_clk);
          if (snp_valid === 1'b1)
            seen = 1'b1;
        end
        rack <= 4'h2;
        @(posedge core_clk);
        rack <= 4'h0;
      end
    join
    chk(seen, 1'b0);
    chk(ns, 1);
  endtask : t_ack
  // master 1 mid line read: its snoop waits for the last beat
  task automatic t_line();
    logic seen = 1'b0;
    run(txn_read_shared, 2'h1, 4'h0);
    rbeat_valid <= 4'h2;
    @(posedge core_clk);
    rbeat_valid <= 4'h0;
    fork
      run(txn_read_shared, 2'h0, 4'h2);
      begin
        repeat (6)
        begin
          @(posedge core_clk);
          if (snp_valid === 1'b1)
            seen = 1'b1;
        end
        rbeat_valid <= 4'h2;
        rbeat_last <= 4'h2;
        @(posedge core_clk);
        rbeat_valid <= 4'h0;
        rbeat_last <= 4'h0;
      end
    join
    chk(seen, 1'b0);
    chk(ns, 1);
  endtask : t_line
  // totals of all scenarios: 26 transactions, 25 snoops, last one all snooped
  task automatic t_count();
    avs(1'b0, REG_COUNT, 32'h0);
    chk(rd, 32'h0019_001a);
    avs(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0042);
  endtask : t_count
  // hang guard
  initial
  begin
    #400000;
    fails++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(req_ready, 1'b1);
    t_regs();
    t_quiet();
    t_map();
    t_stops();
    t_ctrl();
    t_ack();
    t_line();
    t_count();
    complete_run();
  end
endmodule : tb_coherent_snoop_issue_control
`default_nettype wire
